// *** design/fee_pkg.sv ***
// constants shared by the flash-backed storage controller
// assumes a 125 MHz bus clock and a word-programmed, sector-erased flash
package fee_pkg;

  localparam int WORD_BYTES   = 2;
  localparam int SECTOR_BYTES = 512;
  localparam int SECTOR_WORDS = SECTOR_BYTES / WORD_BYTES;
  localparam int MIN_SECTORS  = 2;

  // clock figures in kHz
  localparam int BUS_CLOCK_FREQ_KHZ          = 125000;
  localparam int FLASH_OP_CLOCK_FREQ_MIN_KHZ = 150;
  localparam int FLASH_OP_CLOCK_FREQ_MAX_KHZ = 200;
  // smallest divider that keeps the op clock at or under the maximum
  localparam int FLASH_OP_DIV =
    (BUS_CLOCK_FREQ_KHZ + FLASH_OP_CLOCK_FREQ_MAX_KHZ - 1)
    / FLASH_OP_CLOCK_FREQ_MAX_KHZ;

  // word program: op-clock periods plus bus-clock periods
  localparam int WORD_PROGRAM_OP_PERIODS  = 9;
  localparam int WORD_PROGRAM_BUS_PERIODS = 25;
  localparam int WORD_PROGRAM_TIME_CYC =
    WORD_PROGRAM_OP_PERIODS * FLASH_OP_DIV + WORD_PROGRAM_BUS_PERIODS;
  // sector erase: op-clock periods
  localparam int SECTOR_ERASE_OP_PERIODS = 4000;
  localparam int SECTOR_ERASE_TIME_CYC =
    SECTOR_ERASE_OP_PERIODS * FLASH_OP_DIV;
  localparam int WAIT_W = 22;

  localparam int DEF_BANK_WORDS = 64;
  localparam int DEF_NUM_BANKS  = 8;
  localparam int DEF_BASE_WORD  = 0;

  localparam logic [15:0] ERASED_WORD = 16'hffff;
  localparam logic [15:0] SEQ_NONE    = 16'h0000;
  localparam logic [15:0] SEQ_FIRST   = 16'h0001;

  typedef enum logic [3:0] {
    ST_INIT_RD   = 4'h0,
    ST_INIT_CAP  = 4'h1,
    ST_IDLE      = 4'h2,
    ST_HRD       = 4'h3,
    ST_BLANK_RD  = 4'h4,
    ST_BLANK_CAP = 4'h5,
    ST_ERASE     = 4'h6,
    ST_COPY_RD   = 4'h7,
    ST_COPY_CAP  = 4'h8,
    ST_PROG      = 4'h9
  } fee_state_t;

endpackage

// *** design/fee_flash_clk.sv ***
// flash operation clock prescaler
// assumes clk_in is the bus clock; output drives the flash engine
module fee_flash_clk #(
  parameter int DIV = fee_pkg::FLASH_OP_DIV
) (
  input  wire logic clk_in,
  input  wire logic rst_in,
  output logic      fl_clk_out
);

  typedef struct packed {
    logic [15:0] cnt;
    logic        clk;
  } fee_div_t;

  fee_div_t q, d;

  always_comb begin
    d = q;
    // divide the bus clock into the allowed op clock band
    if (q.cnt == 16'(DIV - 1)) begin
      d.cnt = 16'h0000;
    end else begin
      d.cnt = q.cnt + 16'h0001;
    end
    d.clk = (d.cnt < 16'(DIV / 2));
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      // parked at the wrap point so the first rise after reset is a full one
      q     <= '0;
      q.cnt <= 16'(DIV - 1);
    end else begin
      q <= d;
    end
  end

  assign fl_clk_out = q.clk;

  a_div_period: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(q.clk) |-> $past(q.cnt) == 16'(DIV - 1))
    else $error("op clock period differs from divider");

endmodule // fee_flash_clk

// *** design/fee_ctrl.sv ***
// flash-backed word-updatable storage controller
// assumes flash read data is valid in the cycle that fl_rd_out is high
module fee_ctrl #(
  parameter int NUM_BANKS    = fee_pkg::DEF_NUM_BANKS,
  parameter int BANK_WORDS   = fee_pkg::DEF_BANK_WORDS,
  parameter int BASE_WORD    = fee_pkg::DEF_BASE_WORD,
  parameter int PGM_WAIT_CYC = fee_pkg::WORD_PROGRAM_TIME_CYC,
  parameter int ERA_WAIT_CYC = fee_pkg::SECTOR_ERASE_TIME_CYC,
  localparam int BI_W = $clog2(NUM_BANKS),
  localparam int WI_W = $clog2(BANK_WORDS)
) (
  input  wire logic            clk_in,
  input  wire logic            rst_in,
  input  wire logic            host_rd_req_in,
  input  wire logic [WI_W-1:0] host_rd_idx_in,
  output logic                 host_rd_ack_out,
  output logic [15:0]          host_rd_data_out,
  input  wire logic            host_wr_req_in,
  input  wire logic [WI_W-1:0] host_wr_idx_in,
  input  wire logic [15:0]     host_wr_data_in,
  output logic                 host_busy_out,
  output logic                 fl_clk_out,
  output logic [15:0]          fl_addr_out,
  output logic [15:0]          fl_wdata_out,
  output logic                 fl_rd_out,
  output logic                 fl_prog_out,
  output logic                 fl_erase_out,
  input  wire logic [15:0]     fl_rdata_in
);

  localparam int BPS = fee_pkg::SECTOR_WORDS / BANK_WORDS;
  localparam int W   = fee_pkg::WAIT_W;

  typedef struct packed {
    fee_pkg::fee_state_t st;
    logic [BI_W-1:0]     cur;
    logic                cur_valid;
    logic [15:0]         seq;
    logic [BI_W-1:0]     tgt;
    logic [BI_W-1:0]     scan;
    logic [WI_W-1:0]     widx;
    logic [WI_W-1:0]     wr_idx;
    logic [15:0]         wr_data;
    logic [W-1:0]        cnt;
    logic                busy;
    logic                rd_ack;
    logic [15:0]         rd_data;
    logic [15:0]         fl_addr;
    logic [15:0]         fl_wdata;
    logic                fl_rd;
    logic                fl_prog;
    logic                fl_erase;
  } fee_regs_t;

  fee_regs_t q, d;

  function automatic logic [15:0] word_addr(input logic [BI_W-1:0] b,
                                            input logic [WI_W-1:0] w);
    word_addr = 16'(BASE_WORD + int'(b) * BANK_WORDS + int'(w));
  endfunction

  function automatic logic [BI_W-1:0] next_bank(input logic [BI_W-1:0] b);
    if (int'(b) == NUM_BANKS - 1) begin
      next_bank = '0;
    end else begin
      next_bank = b + BI_W'(1);
    end
  endfunction

  function automatic logic [BI_W-1:0] next_sector(input logic [BI_W-1:0] b);
    int s;
    s = (int'(b) / BPS + 1) * BPS;
    if (s >= NUM_BANKS) begin
      s = 0;
    end
    next_sector = BI_W'(s);
  endfunction

  function automatic logic sector_first(input logic [BI_W-1:0] b);
    sector_first = (int'(b) % BPS) == 0;
  endfunction

  // status sequence never takes the erased or the empty value
  function automatic logic [15:0] seq_next(input logic [15:0] s);
    if (s + 16'h0001 == fee_pkg::ERASED_WORD) begin
      seq_next = fee_pkg::SEQ_FIRST;
    end else begin
      seq_next = s + 16'h0001;
    end
  endfunction

  logic [BI_W-1:0] t_bank;
  logic            go_erase;
  logic            go_prog;
  logic [15:0]     prog_data;

  // whole controller is this state machine, no code runs from flash
  always_comb begin
    d         = q;
    d.fl_rd   = 1'b0;
    d.fl_prog = 1'b0;
    d.fl_erase = 1'b0;
    d.rd_ack  = 1'b0;
    t_bank    = q.tgt;
    go_erase  = 1'b0;
    go_prog   = 1'b0;
    prog_data = fee_pkg::ERASED_WORD;
    case (q.st)
      fee_pkg::ST_INIT_RD: begin
        d.fl_rd   = 1'b1;
        d.fl_addr = word_addr(q.scan, WI_W'(BANK_WORDS - 1));
        d.st      = fee_pkg::ST_INIT_CAP;
      end
      fee_pkg::ST_INIT_CAP: begin
        // unwritten status means a partial bank: never selected
        if (fl_rdata_in != fee_pkg::ERASED_WORD &&
            fl_rdata_in != fee_pkg::SEQ_NONE &&
            (!q.cur_valid || fl_rdata_in > q.seq)) begin
          d.cur       = q.scan;
          d.cur_valid = 1'b1;
          d.seq       = fl_rdata_in;
        end
        if (int'(q.scan) == NUM_BANKS - 1) begin
          d.busy = 1'b0;
          d.st   = fee_pkg::ST_IDLE;
        end else begin
          d.scan = q.scan + BI_W'(1);
          d.st   = fee_pkg::ST_INIT_RD;
        end
      end
      fee_pkg::ST_IDLE: begin
        // status word index is not a variable, such writes are dropped
        if (host_wr_req_in && int'(host_wr_idx_in) < BANK_WORDS - 1) begin
          d.busy    = 1'b1;
          d.wr_idx  = host_wr_idx_in;
          d.wr_data = host_wr_data_in;
          d.widx    = '0;
          t_bank    = q.cur_valid ? next_bank(q.cur) : '0;
          d.tgt     = t_bank;
          if (sector_first(t_bank)) begin
            go_erase = 1'b1;
          end else begin
            d.st = fee_pkg::ST_BLANK_RD;
          end
        end else if (host_rd_req_in) begin
          if (q.cur_valid) begin
            d.fl_rd   = 1'b1;
            d.fl_addr = word_addr(q.cur, host_rd_idx_in);
            d.st      = fee_pkg::ST_HRD;
          end else begin
            d.rd_ack  = 1'b1;
            d.rd_data = fee_pkg::ERASED_WORD;
          end
        end
      end
      fee_pkg::ST_HRD: begin
        d.rd_data = fl_rdata_in;
        d.rd_ack  = 1'b1;
        d.st      = fee_pkg::ST_IDLE;
      end
      fee_pkg::ST_BLANK_RD: begin
        d.fl_rd   = 1'b1;
        d.fl_addr = word_addr(q.tgt, q.widx);
        d.st      = fee_pkg::ST_BLANK_CAP;
      end
      fee_pkg::ST_BLANK_CAP: begin
        // leftover of an interrupted update: move to a fresh sector
        if (fl_rdata_in != fee_pkg::ERASED_WORD) begin
          t_bank   = next_sector(q.tgt);
          d.tgt    = t_bank;
          d.widx   = '0;
          go_erase = 1'b1;
        end else if (int'(q.widx) == BANK_WORDS - 1) begin
          d.widx = '0;
          d.st   = fee_pkg::ST_COPY_RD;
        end else begin
          d.widx = q.widx + WI_W'(1);
          d.st   = fee_pkg::ST_BLANK_RD;
        end
      end
      fee_pkg::ST_ERASE: begin
        if (q.cnt == '0) begin
          d.widx = '0;
          d.st   = fee_pkg::ST_COPY_RD;
        end else begin
          d.cnt = q.cnt - W'(1);
        end
      end
      fee_pkg::ST_COPY_RD: begin
        if (int'(q.widx) == BANK_WORDS - 1) begin
          go_prog   = 1'b1;
          prog_data = q.cur_valid ? seq_next(q.seq) : fee_pkg::SEQ_FIRST;
        end else if (q.widx == q.wr_idx) begin
          go_prog   = 1'b1;
          prog_data = q.wr_data;
        end else if (!q.cur_valid) begin
          go_prog   = 1'b1;
        end else begin
          d.fl_rd   = 1'b1;
          d.fl_addr = word_addr(q.cur, q.widx);
          d.st      = fee_pkg::ST_COPY_CAP;
        end
      end
      fee_pkg::ST_COPY_CAP: begin
        go_prog   = 1'b1;
        prog_data = fl_rdata_in;
      end
      fee_pkg::ST_PROG: begin
        if (q.cnt != '0) begin
          d.cnt = q.cnt - W'(1);
        end else if (int'(q.widx) == BANK_WORDS - 1) begin
          d.cur       = q.tgt;
          d.cur_valid = 1'b1;
          d.seq       = q.fl_wdata;
          d.busy      = 1'b0;
          d.st        = fee_pkg::ST_IDLE;
        end else begin
          d.widx = q.widx + WI_W'(1);
          d.st   = fee_pkg::ST_COPY_RD;
        end
      end
      default: begin
        d.st = fee_pkg::ST_IDLE;
      end
    endcase
    if (go_erase) begin
      // target is always sector-first, the current bank lies elsewhere
      d.fl_erase = 1'b1;
      d.fl_addr  = word_addr(t_bank, '0);
      d.cnt      = W'(ERA_WAIT_CYC - 1);
      d.st       = fee_pkg::ST_ERASE;
    end
    if (go_prog) begin
      d.fl_prog  = 1'b1;
      d.fl_addr  = word_addr(q.tgt, q.widx);
      d.fl_wdata = prog_data;
      d.cnt      = W'(PGM_WAIT_CYC - 1);
      d.st       = fee_pkg::ST_PROG;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      q      <= '0;
      q.st   <= fee_pkg::ST_INIT_RD;
      q.busy <= 1'b1;
    end else begin
      q <= d;
    end
  end

  fee_flash_clk #(
    .DIV (fee_pkg::FLASH_OP_DIV)
  ) u_flash_clk (
    .clk_in     (clk_in),
    .rst_in     (rst_in),
    .fl_clk_out (fl_clk_out)
  );

  assign host_rd_ack_out  = q.rd_ack;
  assign host_rd_data_out = q.rd_data;
  assign host_busy_out    = q.busy;
  assign fl_addr_out      = q.fl_addr;
  assign fl_wdata_out     = q.fl_wdata;
  assign fl_rd_out        = q.fl_rd;
  assign fl_prog_out      = q.fl_prog;
  assign fl_erase_out     = q.fl_erase;

  // helper state for the checks below
  logic [W-1:0]  since_prog_q;
  logic [W-1:0]  since_era_q;
  logic [15:0]   last_pa_q;
  logic          last_pa_v_q;
  logic [WI_W:0] nprog_q;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      since_prog_q <= '1;
      since_era_q  <= '1;
      last_pa_q    <= '0;
      last_pa_v_q  <= 1'b0;
      nprog_q      <= '0;
    end else begin
      since_prog_q <= fl_prog_out ? W'(1) :
                      (&since_prog_q ? since_prog_q : since_prog_q + W'(1));
      since_era_q  <= fl_erase_out ? W'(1) :
                      (&since_era_q ? since_era_q : since_era_q + W'(1));
      if (fl_erase_out) begin
        last_pa_v_q <= 1'b0;
      end else if (fl_prog_out) begin
        last_pa_q   <= fl_addr_out;
        last_pa_v_q <= 1'b1;
      end
      if (host_wr_req_in && q.st == fee_pkg::ST_IDLE) begin
        nprog_q <= '0;
      end else if (fl_prog_out) begin
        nprog_q <= nprog_q + (WI_W+1)'(1);
      end
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_prog_spacing: assert property (fl_prog_out && since_prog_q != '1 |->
    since_prog_q >= W'(PGM_WAIT_CYC)) else $error("word program cut short");
  a_erase_time: assert property (fl_prog_out && since_era_q != '1 |->
    since_era_q >= W'(ERA_WAIT_CYC)) else $error("erase cut short");
  a_no_read_busy: assert property (
    (q.st == fee_pkg::ST_PROG || q.st == fee_pkg::ST_ERASE) |-> !fl_rd_out)
    else $error("flash read during program or erase");
  a_no_reprogram: assert property (fl_prog_out && last_pa_v_q |->
    fl_addr_out != last_pa_q) else $error("word programmed twice");
  a_erase_aligned: assert property (fl_erase_out |->
    ((int'(fl_addr_out) - BASE_WORD) % fee_pkg::SECTOR_WORDS) == 0)
    else $error("erase not sector aligned");
  a_keep_current: assert property (fl_erase_out && q.cur_valid |->
    (int'(fl_addr_out) - BASE_WORD) / fee_pkg::SECTOR_WORDS !=
    int'(q.cur) / BPS) else $error("current bank erased");
  a_whole_bank: assert property (
    $fell(host_busy_out) && $past(q.st) == fee_pkg::ST_PROG |->
    nprog_q == (WI_W+1)'(BANK_WORDS)) else $error("bank not fully written");
  a_status_last: assert property (fl_prog_out &&
    int'(q.widx) == BANK_WORDS - 1 |-> fl_wdata_out != fee_pkg::ERASED_WORD &&
    fl_wdata_out != fee_pkg::SEQ_NONE &&
    nprog_q == (WI_W+1)'(BANK_WORDS - 1)) else $error("bad status word");
  a_addr_in_area: assert property (
    (fl_rd_out || fl_prog_out || fl_erase_out) |->
    int'(fl_addr_out) >= BASE_WORD &&
    int'(fl_addr_out) < BASE_WORD + NUM_BANKS * BANK_WORDS &&
    NUM_BANKS * BANK_WORDS >= fee_pkg::MIN_SECTORS * fee_pkg::SECTOR_WORDS)
    else $error("flash access outside reserved area");
  a_status_value: assert property (
    $fell(host_busy_out) && $past(q.st) == fee_pkg::ST_PROG |->
    q.seq == $past(q.fl_wdata) && q.seq != fee_pkg::ERASED_WORD)
    else $error("status word not adopted");
  a_read_gated: assert property (host_rd_ack_out |-> !host_busy_out)
    else $error("read served during update");
  a_busy_accept: assert property (
    host_wr_req_in && q.st == fee_pkg::ST_IDLE &&
    int'(host_wr_idx_in) < BANK_WORDS - 1 |=> host_busy_out [*2])
    else $error("busy not raised on update");
  a_erase_first: assert property (
    fl_erase_out |=> !fl_prog_out) else $error("program right after erase");

  c_update_erase: cover property (fl_erase_out ##1 host_busy_out [*3]);
  c_update_plain: cover property (
    q.st == fee_pkg::ST_BLANK_CAP && int'(q.widx) == BANK_WORDS - 1);
  c_host_read: cover property (host_rd_ack_out && q.cur_valid);
  c_update_done: cover property ($fell(host_busy_out));

endmodule // fee_ctrl

// *** verif/fee_flash_model.sv ***
// behavioural flash array with a timed program/erase engine
// assumes one-cycle program and erase pulses on the bus clock
module fee_flash_model #(
  parameter int PGM_WAIT = 20,
  parameter int ERA_WAIT = 50,
  parameter int BANK_W   = 64
) (
  input  wire logic        clk_in,
  input  wire logic [15:0] fl_addr_in,
  input  wire logic [15:0] fl_wdata_in,
  input  wire logic        fl_rd_in,
  input  wire logic        fl_prog_in,
  input  wire logic        fl_erase_in,
  output logic [15:0]      fl_rdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WORDS = 512;
  localparam int SECT  = 256;
  logic [15:0] mem [WORDS];
  bit          written [WORDS];
  logic [15:0] last_q;
  int          busy_cnt, err_cnt, prog_cnt, last_off, cur_bank, a;

  initial begin
    for (int i = 0; i < WORDS; i++) begin
      mem[i] = 16'hffff;
      written[i] = 1'b0;
    end
    last_q = 16'h0000;
    cur_bank = -1;
  end

  // unselected bus does not keep the last word
  assign fl_rdata_out = fl_rd_in ? mem[fl_addr_in[8:0]] : ~last_q;

  task automatic bad(string m);
    err_cnt++;
    $display("CHECK FAILED flash %s expected no fault seen fault", m);
  endtask

  always @(posedge clk_in) begin
    a = int'(fl_addr_in[8:0]);
    if (busy_cnt > 0)
      busy_cnt <= busy_cnt - 1;
    if ((fl_rd_in || fl_prog_in || fl_erase_in) && fl_addr_in >= WORDS)
      bad("address outside area");
    if (fl_rd_in && busy_cnt != 0)
      bad("read while engine busy");
    if (fl_rd_in)
      last_q <= mem[a];
    if (fl_prog_in) begin
      if (busy_cnt != 0)
        bad("program started early");
      if (written[a])
        bad("word programmed twice");
      mem[a] <= mem[a] & fl_wdata_in;
      written[a] <= 1'b1;
      busy_cnt <= PGM_WAIT - 1;
      prog_cnt++;
      last_off = a % BANK_W;
      if (last_off == BANK_W - 1)
        cur_bank <= a / BANK_W;
    end
    if (fl_erase_in) begin
      if (busy_cnt != 0)
        bad("erase started early");
      if (a % SECT != 0)
        bad("erase not sector aligned");
      if (cur_bank >= 0 && cur_bank * BANK_W / SECT == a / SECT)
        bad("erase of current set");
      for (int i = 0; i < SECT; i++) begin
        mem[a + i] <= 16'hffff;
        written[a + i] <= 1'b0;
      end
      busy_cnt <= ERA_WAIT - 1;
    end
  end
endmodule // fee_flash_model

// *** verif/tb_flash_backed_eeprom_emulation.sv ***
// self-checking bench for the flash-backed storage controller
// assumes fee_flash_model stands in for the flash array
module tb_flash_backed_eeprom_emulation;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NB = 8;
  localparam int BW = 64;
  localparam int PW = 20;
  localparam int EW = 50;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        host_rd_req_in = 1'b0;
  logic        host_wr_req_in = 1'b0;
  logic [5:0]  host_rd_idx_in = 6'h00;
  logic [5:0]  host_wr_idx_in = 6'h00;
  logic [15:0] host_wr_data_in = 16'h0000;
  logic        host_rd_ack_out, host_busy_out, fl_clk_out;
  logic        fl_rd_out, fl_prog_out, fl_erase_out;
  logic [15:0] host_rd_data_out, fl_addr_out, fl_wdata_out, fl_rdata_in;
  logic [15:0] shadow [BW];
  logic [15:0] exp_q [$];
  logic [15:0] lfsr = 16'h000a;
  int          err_total = 0;
  int          comparisons = 0;
  int          seq = 0;

  always #4 clk_in = ~clk_in;

  fee_ctrl #(.NUM_BANKS(NB), .BANK_WORDS(BW), .BASE_WORD(0),
             .PGM_WAIT_CYC(PW), .ERA_WAIT_CYC(EW)) uut (
    .clk_in(clk_in), .rst_in(rst_in),
    .host_rd_req_in(host_rd_req_in), .host_rd_idx_in(host_rd_idx_in),
    .host_rd_ack_out(host_rd_ack_out), .host_rd_data_out(host_rd_data_out),
    .host_wr_req_in(host_wr_req_in), .host_wr_idx_in(host_wr_idx_in),
    .host_wr_data_in(host_wr_data_in), .host_busy_out(host_busy_out),
    .fl_clk_out(fl_clk_out), .fl_addr_out(fl_addr_out),
    .fl_wdata_out(fl_wdata_out), .fl_rd_out(fl_rd_out),
    .fl_prog_out(fl_prog_out), .fl_erase_out(fl_erase_out),
    .fl_rdata_in(fl_rdata_in));

  fee_flash_model #(.PGM_WAIT(PW), .ERA_WAIT(EW), .BANK_W(BW)) u_flash (
    .clk_in(clk_in), .fl_addr_in(fl_addr_out), .fl_wdata_in(fl_wdata_out),
    .fl_rd_in(fl_rd_out), .fl_prog_in(fl_prog_out),
    .fl_erase_in(fl_erase_out), .fl_rdata_out(fl_rdata_in));

  function automatic logic [15:0] nxt(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tick(int n = 1);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task automatic test_done();
    chk("flash model faults", 0, u_flash.err_cnt);
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // scoreboard: every read ack takes the oldest expectation
  always @(posedge clk_in) begin
    if (host_rd_ack_out === 1'b1) begin
      if (exp_q.size() == 0)
        chk("unexpected read ack", 0, 1);
      else
        chk("read data", {16'h0, exp_q.pop_front()}, {16'h0, host_rd_data_out});
    end
  end

  task automatic wait_idle();
    for (int i = 0; i < 4000 && host_busy_out !== 1'b0; i++)
      tick();
    chk("busy released", 0, {31'h0, host_busy_out});
  endtask

  task automatic do_read(logic [5:0] idx, logic [15:0] e);
    exp_q.push_back(e);
    host_rd_idx_in = idx;
    host_rd_req_in = 1'b1;
    tick();
    host_rd_req_in = 1'b0;
    for (int i = 0; i < 8 && host_rd_ack_out !== 1'b1; i++)
      tick();
    chk("read ack", 1, {31'h0, host_rd_ack_out});
    tick();
  endtask

  task automatic do_write(logic [5:0] idx, logic [15:0] d);
    int p0;
    p0 = u_flash.prog_cnt;
    host_wr_idx_in = idx;
    host_wr_data_in = d;
    host_wr_req_in = 1'b1;
    tick();
    host_wr_req_in = 1'b0;
    tick();
    chk("busy after accept", 1, {31'h0, host_busy_out});
    // a read during the update must draw no ack
    host_rd_req_in = 1'b1;
    tick();
    host_rd_req_in = 1'b0;
    wait_idle();
    shadow[idx] = d;
    seq++;
    chk("words per update", BW, u_flash.prog_cnt - p0);
    chk("status word last", BW - 1, u_flash.last_off);
  endtask

  task automatic wait_lvl(logic v, output int n);
    for (n = 0; n < 2000 && fl_clk_out !== v; n++)
      tick();
  endtask

  task automatic measure_opclk();
    int n, lo, hi;
    wait_lvl(1'b0, n);
    wait_lvl(1'b1, n);
    wait_lvl(1'b0, hi);
    wait_lvl(1'b1, lo);
    // 150 to 200 kHz is 625 to 833 bus cycles
    chk("op clock period", 1, 32'(hi + lo >= 625 && hi + lo <= 833));
  endtask

  task automatic sweep();
    for (int i = 0; i < BW - 1; i++)
      do_read(6'(i), shadow[i]);
    do_read(6'h3f, 16'(seq));
  endtask

  initial begin
    logic [5:0] ix;
    for (int i = 0; i < BW; i++)
      shadow[i] = 16'hffff;
    tick(20);
    rst_in = 1'b0;
    tick();
    chk("busy during scan", 1, {31'h0, host_busy_out});
    wait_idle();
    do_read(6'h05, 16'hffff);
    // the status slot is not a variable
    host_wr_idx_in = 6'h3f;
    host_wr_req_in = 1'b1;
    tick();
    host_wr_req_in = 1'b0;
    tick(2);
    chk("status index refused", 0, {31'h0, host_busy_out});
    fork
      measure_opclk();
      do_write(6'h00, 16'h0001);
    join
    // enough updates to wrap both sectors and force erases
    for (int k = 0; k < 9; k++) begin
      lfsr = nxt(lfsr);
      ix = 6'(lfsr % 16'd63);
      lfsr = nxt(lfsr);
      do_write(ix, lfsr);
      do_read(ix, shadow[ix]);
      do_read(6'h3f, 16'(seq));
    end
    sweep();
    // half-written next bank, as after a power loss
    u_flash.mem[((u_flash.cur_bank + 1) % NB) * BW] = 16'h1234;
    u_flash.written[((u_flash.cur_bank + 1) % NB) * BW] = 1'b1;
    rst_in = 1'b1;
    tick(3);
    rst_in = 1'b0;
    tick();
    wait_idle();
    sweep();
    do_write(6'h3e, 16'h5aa5);
    sweep();
    test_done();
  end

  initial begin
    tick(60000);
    chk("watchdog", 0, 1);
    test_done();
  end
endmodule // tb_flash_backed_eeprom_emulation
